// *** rtl/plfr_pkg.sv ***
package plfr_pkg;
	// Timing figures in their own units, cycle counts derived from the core clock
	localparam longint CLK_HZ = 20_000_000;
	localparam longint UV_TRIP_MS = 15;
	localparam longint RIDE_WAIT_MS = 500;
	localparam longint CLEAN_RUN_MIN = 10;
	localparam longint UV_TRIP_CYC = (UV_TRIP_MS * CLK_HZ + 999) / 1000;
	localparam longint RIDE_WAIT_CYC = (RIDE_WAIT_MS * CLK_HZ + 999) / 1000;
	localparam longint CLEAN_RUN_CYC = CLEAN_RUN_MIN * 60 * CLK_HZ;
	localparam int TW = 34;
	localparam int AW = 14;

	// Register indices; byte address is four times the index
	localparam logic [11:0] IDX_MODE = 12'h151;
	localparam logic [11:0] IDX_RTLIM = 12'h152;
	localparam logic [11:0] IDX_STAT = 12'h160;
	localparam logic [11:0] IDX_MASK = 12'h161;
	localparam logic [11:0] IDX_INFO = 12'h162;
	localparam logic [11:0] IDX_MFO = 12'h170;
	localparam int N_MFO = 3;

	localparam logic [3:0] RTLIM_RST = 4'h0;
	localparam logic [3:0] RETRY_MAX = 4'ha;
	localparam logic [7:0] MFO_RETRY = 8'h0e;
	localparam logic [7:0] MFO_RST = 8'h00;

	// Sticky status bits
	localparam int NSB = 4;
	localparam int SB_UVW = 0;
	localparam int SB_UVF = 1;
	localparam int SB_RETRY = 2;
	localparam int SB_TRIP = 3;

	// Info register fields
	localparam int INF_STATE = 4;
	localparam int INF_UVW = 8;
	localparam int INF_UVF = 9;
	localparam int INF_RETRY = 10;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_TIMED = 2'b01,
		MODE_RESTART = 2'b10
	} plfr_mode_t;

	typedef enum logic [2:0] {
		ST_STOP = 3'b000,
		ST_RUN = 3'b001,
		ST_RIDE = 3'b010,
		ST_SEARCH = 3'b011,
		ST_TRIP = 3'b100
	} plfr_state_t;
endpackage : plfr_pkg

// *** rtl/plfr_tmr_if.sv ***
`timescale 1ns/1ps
interface plfr_tmr_if #(parameter int W = 34);
	logic run;
	logic [W-1:0] limit;
	logic done;
	modport ctl(output run, output limit, input done);
	modport tmr(input run, input limit, output done);
endinterface : plfr_tmr_if

// *** rtl/plfr_timer.sv ***
`timescale 1ns/1ps
module plfr_timer #(parameter int W = 34) (
	input wire logic clk,
	input wire logic rstn,
	plfr_tmr_if.tmr t
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;

	// Saturates at the limit so done stays up until run drops
	always_comb begin
		if (!t.run) begin
			next_cnt = '0;
		end else if (cnt == t.limit) begin
			next_cnt = cnt;
		end else begin
			next_cnt = cnt + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	assign t.done = t.run && (cnt == t.limit);
endmodule : plfr_timer

// *** rtl/plfr_ctrl.sv ***
`timescale 1ns/1ps
module plfr_ctrl
	import plfr_pkg::*;
#(
	parameter longint UV_CYC = UV_TRIP_CYC,
	parameter longint RIDE_CYC = RIDE_WAIT_CYC,
	parameter longint CLEAN_CYC = CLEAN_RUN_CYC
) (
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic [AW-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [AW-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic SUPPLY_LOSS,
	input wire logic OV_FAULT,
	input wire logic OC_FAULT,
	input wire logic OTHER_FAULT,
	input wire logic FAULT_RESET,
	input wire logic RUN_CMD,
	input wire logic SEARCH_DONE,
	output logic DRIVE_ON,
	output logic SPEED_SEARCH,
	output logic UNDERVOLTAGE_WARNING,
	output logic MAIN_UNDERVOLTAGE_FAULT,
	output logic FAULT_TRIP,
	output logic [N_MFO-1:0] MFO,
	output logic IRQ
);
	logic [6:0] sync1, sync2;
	logic s_loss, s_ov, s_oc, s_other, s_freset, s_run, s_sdone;
	logic ovoc_q, ovoc_edge;
	plfr_state_t state, next_state;
	plfr_mode_t mode, next_mode;
	logic [3:0] lim, next_lim, retry_cnt, next_cnt;
	logic [NSB-1:0] stat, next_stat, mask, next_mask, w1c, ev;
	logic [7:0] mfo_sel [N_MFO];
	logic [7:0] next_mfo [N_MFO];
	logic uvw, next_uvw, uvf, next_uvf, retrying, next_retrying, trip_now;
	logic aw_got, next_aw_got, w_got, next_w_got, do_wr;
	logic [AW-1:0] waddr, next_waddr;
	logic [31:0] wdata, next_wdata, rd_val, next_rdata;
	logic [3:0] wstrb, next_wstrb;
	logic next_bvalid, next_awready, next_wready, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [11:0] wr_idx, rd_idx;

	plfr_tmr_if #(.W(TW)) lt();
	plfr_tmr_if #(.W(TW)) ct();

	plfr_timer #(.W(TW)) u_loss_tmr (.clk(CORE_CLK), .rstn(RSTN), .t(lt));
	plfr_timer #(.W(TW)) u_clean_tmr (.clk(CORE_CLK), .rstn(RSTN), .t(ct));

	function automatic logic reg_hit(input logic [11:0] i);
		return i == IDX_MODE || i == IDX_RTLIM || i == IDX_STAT || i == IDX_MASK ||
			i == IDX_INFO || (i >= IDX_MFO && i < IDX_MFO + 12'(N_MFO));
	endfunction : reg_hit

	// Pin inputs cross into the core clock domain
	assign {s_loss, s_ov, s_oc, s_other, s_freset, s_run, s_sdone} = sync2;
	assign ovoc_edge = (s_ov | s_oc) & ~ovoc_q;

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			sync1 <= '0;
			sync2 <= '0;
			ovoc_q <= 1'b0;
		end else begin
			sync1 <= {SUPPLY_LOSS, OV_FAULT, OC_FAULT, OTHER_FAULT, FAULT_RESET, RUN_CMD, SEARCH_DONE};
			sync2 <= sync1;
			ovoc_q <= s_ov | s_oc;
		end
	end

	// Loss timer: 15 ms in mode 0 while running, 0.5 s in mode 1 while riding through
	assign lt.run = (state == ST_RUN && mode == MODE_OFF && s_loss) ||
		(state == ST_RIDE && mode == MODE_TIMED);
	// Done shows at count equal to limit, so mode 0 stops one short to trip at exactly 15 ms
	assign lt.limit = (mode == MODE_OFF) ? TW'(UV_CYC - 1) : TW'(RIDE_CYC);
	// Leaving RUN restarts the clean-run window, so it measures since the last restart
	assign ct.run = state == ST_RUN && retry_cnt != 4'h0;
	assign ct.limit = TW'(CLEAN_CYC);

	// AXI write path
	assign do_wr = aw_got && w_got && !S_AXI_BVALID;
	assign wr_idx = waddr[AW-1:2];
	assign rd_idx = S_AXI_ARADDR[AW-1:2];

	always_comb begin
		next_aw_got = aw_got;
		next_w_got = w_got;
		next_waddr = waddr;
		next_wdata = wdata;
		next_wstrb = wstrb;
		next_bvalid = S_AXI_BVALID;
		next_bresp = S_AXI_BRESP;
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			next_aw_got = 1'b1;
			next_waddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			next_w_got = 1'b1;
			next_wdata = S_AXI_WDATA;
			next_wstrb = S_AXI_WSTRB;
		end
		if (S_AXI_BVALID && S_AXI_BREADY) begin
			next_bvalid = 1'b0;
		end
		if (do_wr) begin
			next_bvalid = 1'b1;
			next_bresp = reg_hit(wr_idx) ? RESP_OKAY : RESP_SLVERR;
			next_aw_got = 1'b0;
			next_w_got = 1'b0;
		end
		next_awready = !next_aw_got;
		next_wready = !next_w_got;
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			waddr <= '0;
			wdata <= '0;
			wstrb <= '0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
		end else begin
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			waddr <= next_waddr;
			wdata <= next_wdata;
			wstrb <= next_wstrb;
			S_AXI_BVALID <= next_bvalid;
			S_AXI_BRESP <= next_bresp;
			S_AXI_AWREADY <= next_awready;
			S_AXI_WREADY <= next_wready;
		end
	end

	// AXI read path
	always_comb begin
		rd_val = '0;
		if (rd_idx == IDX_MODE) begin
			rd_val[1:0] = mode;
		end
		if (rd_idx == IDX_RTLIM) begin
			rd_val[3:0] = lim;
		end
		if (rd_idx == IDX_STAT) begin
			rd_val[NSB-1:0] = stat;
		end
		if (rd_idx == IDX_MASK) begin
			rd_val[NSB-1:0] = mask;
		end
		if (rd_idx == IDX_INFO) begin
			rd_val[3:0] = retry_cnt;
			rd_val[INF_STATE +: 3] = state;
			rd_val[INF_UVW] = uvw;
			rd_val[INF_UVF] = uvf;
			rd_val[INF_RETRY] = retrying;
		end
		for (int i = 0; i < N_MFO; i++) begin
			if (rd_idx == IDX_MFO + 12'(i)) begin
				rd_val[7:0] = mfo_sel[i];
			end
		end
	end

	always_comb begin
		next_rvalid = S_AXI_RVALID;
		next_rdata = S_AXI_RDATA;
		next_rresp = S_AXI_RRESP;
		if (S_AXI_RVALID && S_AXI_RREADY) begin
			next_rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			next_rvalid = 1'b1;
			next_rdata = rd_val;
			next_rresp = reg_hit(rd_idx) ? RESP_OKAY : RESP_SLVERR;
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= RESP_OKAY;
			S_AXI_ARREADY <= 1'b0;
		end else begin
			S_AXI_RVALID <= next_rvalid;
			S_AXI_RDATA <= next_rdata;
			S_AXI_RRESP <= next_rresp;
			S_AXI_ARREADY <= next_arready;
		end
	end

	// Settings, mask and sticky status
	always_comb begin
		next_mode = mode;
		next_lim = lim;
		next_mask = mask;
		next_mfo = mfo_sel;
		w1c = '0;
		if (do_wr && wstrb[0]) begin
			// Illegal values are dropped rather than clamped
			if (wr_idx == IDX_MODE && state == ST_STOP && wdata[15:2] == 14'h0 &&
				wdata[1:0] != 2'b11) begin
				next_mode = plfr_mode_t'(wdata[1:0]);
			end
			if (wr_idx == IDX_RTLIM && state == ST_STOP && wdata[15:0] <= 16'(RETRY_MAX)) begin
				next_lim = wdata[3:0];
			end
			if (wr_idx == IDX_MASK) begin
				next_mask = wdata[NSB-1:0];
			end
			if (wr_idx == IDX_STAT) begin
				w1c = wdata[NSB-1:0];
			end
			for (int i = 0; i < N_MFO; i++) begin
				if (wr_idx == IDX_MFO + 12'(i)) begin
					next_mfo[i] = wdata[7:0];
				end
			end
		end
		// A new event beats a clear in the same cycle
		next_stat = (stat & ~w1c) | ev;
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			mode <= MODE_OFF;
			lim <= RTLIM_RST;
			mask <= '0;
			stat <= '0;
			for (int i = 0; i < N_MFO; i++) begin
				mfo_sel[i] <= MFO_RST;
			end
		end else begin
			mode <= next_mode;
			lim <= next_lim;
			mask <= next_mask;
			stat <= next_stat;
			mfo_sel <= next_mfo;
		end
	end

	// Drive sequencing
	always_comb begin
		next_state = state;
		next_cnt = retry_cnt;
		next_uvw = uvw;
		next_uvf = uvf;
		next_retrying = retrying;
		trip_now = 1'b0;
		ev = '0;
		unique case (state)
			ST_STOP: begin
				if (s_other) begin
					trip_now = 1'b1;
				end else if (s_run) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN, ST_SEARCH: begin
				if (s_other) begin
					trip_now = 1'b1;
				end else if (ovoc_edge) begin
					if (retry_cnt < lim) begin
						next_cnt = retry_cnt + 4'h1;
						next_retrying = 1'b1;
						next_state = ST_SEARCH;
						ev[SB_RETRY] = 1'b1;
					end else begin
						trip_now = 1'b1;
					end
				end else if (state == ST_RUN && s_loss && mode != MODE_OFF) begin
					next_state = ST_RIDE;
					next_uvw = 1'b1;
					ev[SB_UVW] = 1'b1;
				end else if (lt.done) begin
					next_uvf = 1'b1;
					ev[SB_UVF] = 1'b1;
					trip_now = 1'b1;
				end else if (!s_run) begin
					next_state = ST_STOP;
				end else if (state == ST_SEARCH && s_sdone) begin
					next_state = ST_RUN;
					next_retrying = 1'b0;
				end
			end
			ST_RIDE: begin
				if (s_other) begin
					trip_now = 1'b1;
				end else if (!s_loss) begin
					next_state = ST_SEARCH;
					next_uvw = 1'b0;
				end else if (mode == MODE_TIMED && lt.done) begin
					next_uvf = 1'b1;
					ev[SB_UVF] = 1'b1;
					trip_now = 1'b1;
				end
			end
			ST_TRIP: begin
				if (s_freset) begin
					next_state = ST_STOP;
					next_uvf = 1'b0;
				end
			end
			default: begin
				next_state = ST_STOP;
			end
		endcase
		if (trip_now) begin
			next_state = ST_TRIP;
			next_uvw = 1'b0;
			next_retrying = 1'b0;
			ev[SB_TRIP] = 1'b1;
		end
		if (s_freset || ct.done) begin
			next_cnt = 4'h0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			state <= ST_STOP;
			retry_cnt <= 4'h0;
			uvw <= 1'b0;
			uvf <= 1'b0;
			retrying <= 1'b0;
			DRIVE_ON <= 1'b0;
			SPEED_SEARCH <= 1'b0;
			FAULT_TRIP <= 1'b0;
			MFO <= '0;
			IRQ <= 1'b0;
		end else begin
			state <= next_state;
			retry_cnt <= next_cnt;
			uvw <= next_uvw;
			uvf <= next_uvf;
			retrying <= next_retrying;
			DRIVE_ON <= next_state == ST_RUN;
			SPEED_SEARCH <= next_state == ST_SEARCH;
			FAULT_TRIP <= next_state == ST_TRIP;
			for (int i = 0; i < N_MFO; i++) begin
				MFO[i] <= next_mfo[i] == MFO_RETRY && next_retrying;
			end
			IRQ <= |(next_stat & next_mask);
		end
	end

	assign UNDERVOLTAGE_WARNING = uvw;
	assign MAIN_UNDERVOLTAGE_FAULT = uvf;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);

	a_uvf_cause: assert property ($rose(uvf) |-> $past(lt.done) && FAULT_TRIP)
		else $error("undervoltage fault without expired loss timer");
	a_ride_keep: assert property (state == ST_RIDE && !s_loss && !s_other |=>
		state == ST_SEARCH && SPEED_SEARCH && !DRIVE_ON)
		else $error("recovery did not start speed search");
	a_ride_enter: assert property (state == ST_RUN && mode != MODE_OFF && s_loss && !s_other &&
		!ovoc_edge |=> state == ST_RIDE && UNDERVOLTAGE_WARNING && !DRIVE_ON)
		else $error("interruption not handled by ride-through");
	a_timed_expire: assert property (state == ST_RIDE && mode == MODE_TIMED && s_loss &&
		lt.done && !s_other |=> FAULT_TRIP && MAIN_UNDERVOLTAGE_FAULT)
		else $error("timed ride-through did not trip");
	a_wait_forever: assert property (state == ST_RIDE && mode == MODE_RESTART && s_loss &&
		!s_other |=> state == ST_RIDE && !MAIN_UNDERVOLTAGE_FAULT)
		else $error("unlimited wait left early");
	a_retry_count: assert property (state == ST_RUN && ovoc_edge && !s_other && retry_cnt < lim
		&& !s_freset |=> state == ST_SEARCH && retry_cnt == $past(retry_cnt) + 4'h1)
		else $error("retry not taken");
	a_limit_trip: assert property (state inside {ST_RUN, ST_SEARCH} && ovoc_edge &&
		retry_cnt >= lim |=> FAULT_TRIP && retry_cnt <= lim)
		else $error("retry beyond limit");
	a_other_trip: assert property (state != ST_TRIP && s_other |=> FAULT_TRIP && !retrying)
		else $error("other fault not tripped");
	a_mfo_retry: assert property (mfo_sel[0] == MFO_RETRY |-> MFO[0] == retrying)
		else $error("retry output wrong");
	a_limit_range: assert property (lim <= RETRY_MAX && retry_cnt <= RETRY_MAX)
		else $error("retry limit out of range");
	a_clean_clear: assert property (ct.done |=> retry_cnt == 4'h0)
		else $error("clean run did not clear count");
	a_reset_clear: assert property (s_freset |=> retry_cnt == 4'h0 ##1 retry_cnt <= 4'h1)
		else $error("fault reset did not clear count");
	a_cfg_locked: assert property (state != ST_STOP |=> $stable(mode) && $stable(lim))
		else $error("setting changed while running");

	c_retry: cover property (state == ST_SEARCH && retrying ##1 state == ST_RUN);
	c_ride_ok: cover property (state == ST_RIDE ##1 state == ST_SEARCH);
	c_uv_trip: cover property ($rose(MAIN_UNDERVOLTAGE_FAULT));
	c_irq: cover property ($rose(IRQ));
endmodule : plfr_ctrl

// *** verif/plfr_drive_model.sv ***
`timescale 1ns/1ps
// Power stage stand-in: reports speed search finished after a chosen lag
module plfr_drive_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic speed_search,
	input wire logic [3:0] lag,
	output logic search_done
);
	logic [3:0] n;
	// Done drops with the request, so a stale done never ends the next search early
	always @(posedge clk) begin
		if (!rstn || !speed_search) begin
			n <= 4'h0;
			search_done <= 1'b0;
		end else if (n >= lag) begin
			search_done <= 1'b1;
		end else begin
			n <= n + 4'h1;
		end
	end
endmodule : plfr_drive_model

// *** verif/tb_power_loss_and_fault_retry_ctrl.sv ***
`timescale 1ns/1ps
module tb_power_loss_and_fault_retry_ctrl
	import plfr_pkg::*;
;
	localparam logic [1:0] OK = RESP_OKAY;
	localparam logic [1:0] ER = RESP_SLVERR;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [AW-1:0] awaddr = '0;
	logic [AW-1:0] araddr = '0;
	logic [31:0] wdata = 32'h0;
	logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
	logic loss = 1'b0, run = 1'b0;
	logic [3:0] flt = 4'h0; // ov, oc, other, fault reset
	logic [3:0] lag = 4'h0;
	wire awr, wrdy, bv, arr, rv, sd, don, srch, uvw, uvf, trip, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [N_MFO-1:0] mfo;
	// Bit order: drive, search, warning, uv fault, trip, irq, retry outputs 0 to 2
	wire [8:0] o = {mfo, irq, trip, uvf, uvw, srch, don};
	int bad_count = 0;
	int num_checks = 0;
	logic [31:0] s = 32'hbc7f;
	logic [65:0] rq[$];
	logic [1:0] bq[$];

	plfr_ctrl #(.UV_CYC(20), .RIDE_CYC(50), .CLEAN_CYC(100)) uut (
		.CORE_CLK(clk), .RSTN(rstn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .SUPPLY_LOSS(loss),
		.OV_FAULT(flt[0]), .OC_FAULT(flt[1]), .OTHER_FAULT(flt[2]), .FAULT_RESET(flt[3]),
		.RUN_CMD(run), .SEARCH_DONE(sd), .DRIVE_ON(don), .SPEED_SEARCH(srch),
		.UNDERVOLTAGE_WARNING(uvw), .MAIN_UNDERVOLTAGE_FAULT(uvf), .FAULT_TRIP(trip),
		.MFO(mfo), .IRQ(irq));
	plfr_drive_model pm (.clk(clk), .rstn(rstn), .speed_search(srch), .lag(lag),
		.search_done(sd));

	initial forever #25 clk = ~clk;

	function automatic logic [31:0] nx();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : nx

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize

	task automatic bad(input string m);
		bad_count++;
		$display("MISMATCH t=%0t %s", $time, m);
	endtask : bad

	task automatic tmo();
		bad("wait ran out");
		summarize();
	endtask : tmo

	task automatic fin(input string nm);
		$display("test %s done", nm);
	endtask : fin

	task automatic chk_p(input int b, input logic v);
		num_checks++;
		if (o[b] !== v) bad($sformatf("pin %0d", b));
	endtask : chk_p

	task automatic chk_r(input logic [65:0] e);
		num_checks++;
		if (((rdata & e[65:34]) !== e[33:2]) || (rresp !== e[1:0])) bad("read data");
	endtask : chk_r

	task automatic chk_b(input logic [1:0] e);
		num_checks++;
		if (bresp !== e) bad("write response");
	endtask : chk_b

	always @(posedge clk) begin
		if (rv === 1'b1 && rready) chk_r(rq.pop_front());
		if (bv === 1'b1 && bready) chk_b(bq.pop_front());
	end

	task automatic rst();
		@(posedge clk);
		rstn <= 1'b0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : rst

	task automatic wr(input logic [11:0] i, input logic [31:0] d, input logic [1:0] e);
		int n;
		bq.push_back(e);
		@(posedge clk);
		awaddr <= {i, 2'b00};
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrdy) wv <= 1'b0;
			if (bv === 1'b1) break;
		end
		bready <= 1'b0;
		if (n == 40) tmo();
	endtask : wr

	task automatic rd(input logic [11:0] i, input logic [31:0] m, input logic [31:0] d,
			input logic [1:0] e);
		int n;
		rq.push_back({m, d, e});
		@(posedge clk);
		araddr <= {i, 2'b00};
		arv <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
			if (rv === 1'b1) break;
		end
		rready <= 1'b0;
		if (n == 40) tmo();
	endtask : rd

	task automatic wt(input int b, input logic v, input int lim);
		int n;
		for (n = 0; n < lim && o[b] !== v; n++) @(posedge clk);
		num_checks++;
		if (o[b] !== v) tmo();
	endtask : wt

	task automatic pl(input int k);
		@(posedge clk);
		flt[k] <= 1'b1;
		repeat (3) @(posedge clk);
		flt[k] <= 1'b0;
	endtask : pl

	// Partner lag is redrawn on every run or loss pin change so searches end both fast and slow
	task automatic drv(input logic r, input logic l);
		@(posedge clk);
		run <= r;
		loss <= l;
		lag <= 4'(nx());
	endtask : drv

	task automatic retry(input logic [31:0] cnt);
		pl(0);
		wt(6, 1'b1, 10);
		chk_p(7, 1'b1);
		chk_p(8, 1'b0);
		chk_p(1, 1'b1);
		wt(0, 1'b1, 40);
		rd(IDX_INFO, 32'hf, cnt, OK);
	endtask : retry

	initial begin
		rst();
		rd(IDX_MODE, 32'hffff, 32'h0, OK);
		rd(IDX_RTLIM, 32'hffff, 32'h0, OK);
		rd(IDX_MFO, 32'hff, 32'h0, OK);
		rd(12'h100, 32'hffffffff, 32'h0, ER);
		wr(12'h100, 32'h1, ER);
		wr(IDX_RTLIM, 32'ha, OK);
		wr(IDX_RTLIM, 32'hb, OK);
		rd(IDX_RTLIM, 32'hf, 32'ha, OK);
		wr(IDX_MODE, 32'h3, OK);
		rd(IDX_MODE, 32'h3, 32'h0, OK);
		wr(IDX_MFO, {24'h0, MFO_RETRY}, OK);
		wr(IDX_MFO + 12'h1, {24'h0, MFO_RETRY}, OK);
		wr(IDX_MFO + 12'h2, 32'hd, OK);
		rd(IDX_MFO + 12'h2, 32'hff, 32'hd, OK);
		fin("registers");
		drv(1'b1, 1'b0);
		wt(0, 1'b1, 20);
		drv(1'b1, 1'b1);
		repeat (5 + nx() % 10) @(posedge clk);
		drv(1'b1, 1'b0);
		repeat (6) @(posedge clk);
		chk_p(3, 1'b0);
		chk_p(0, 1'b1);
		drv(1'b1, 1'b1);
		wt(3, 1'b1, 40);
		chk_p(4, 1'b1);
		chk_p(5, 1'b0);
		drv(1'b0, 1'b0);
		pl(3);
		wt(4, 1'b0, 20);
		rd(IDX_STAT, 32'hf, 32'ha, OK);
		wr(IDX_STAT, 32'hf, OK);
		wr(IDX_MASK, 32'hf, OK);
		fin("trip");
		wr(IDX_MODE, 32'h1, OK);
		drv(1'b1, 1'b0);
		wt(0, 1'b1, 20);
		wr(IDX_MODE, 32'h2, OK);
		rd(IDX_MODE, 32'h3, 32'h1, OK);
		drv(1'b1, 1'b1);
		wt(2, 1'b1, 10);
		chk_p(0, 1'b0);
		repeat (nx() % 30) @(posedge clk);
		drv(1'b1, 1'b0);
		wt(1, 1'b1, 20);
		wt(0, 1'b1, 40);
		chk_p(3, 1'b0);
		drv(1'b1, 1'b1);
		repeat (40) @(posedge clk);
		chk_p(3, 1'b0);
		wt(3, 1'b1, 30);
		drv(1'b0, 1'b0);
		pl(3);
		wt(4, 1'b0, 20);
		wr(IDX_MODE, 32'h2, OK);
		drv(1'b1, 1'b0);
		wt(0, 1'b1, 20);
		drv(1'b1, 1'b1);
		repeat (150) @(posedge clk);
		chk_p(2, 1'b1);
		chk_p(3, 1'b0);
		drv(1'b1, 1'b0);
		wt(1, 1'b1, 20);
		wt(0, 1'b1, 40);
		chk_p(5, 1'b1);
		wr(IDX_STAT, 32'hf, OK);
		wt(5, 1'b0, 10);
		fin("ride through");
		drv(1'b0, 1'b0);
		wt(0, 1'b0, 10);
		wr(IDX_RTLIM, 32'h2, OK);
		drv(1'b1, 1'b0);
		wt(0, 1'b1, 20);
		retry(32'h1);
		chk_p(6, 1'b0);
		chk_p(5, 1'b1);
		retry(32'h2);
		pl(1);
		wt(4, 1'b1, 10);
		chk_p(6, 1'b0);
		rd(IDX_INFO, 32'h7f, 32'h42, OK);
		drv(1'b0, 1'b0);
		pl(3);
		wt(4, 1'b0, 20);
		rd(IDX_INFO, 32'hf, 32'h0, OK);
		drv(1'b1, 1'b0);
		wt(0, 1'b1, 20);
		pl(2);
		wt(4, 1'b1, 10);
		chk_p(6, 1'b0);
		rd(IDX_INFO, 32'h47f, 32'h40, OK);
		drv(1'b0, 1'b0);
		pl(3);
		wt(4, 1'b0, 20);
		drv(1'b1, 1'b0);
		wt(0, 1'b1, 20);
		retry(32'h1);
		repeat (130) @(posedge clk);
		rd(IDX_INFO, 32'hf, 32'h0, OK);
		retry(32'h1);
		drv(1'b0, 1'b0);
		rst();
		rd(IDX_INFO, 32'hf, 32'h0, OK);
		rd(IDX_RTLIM, 32'hffff, 32'h0, OK);
		// Limit 0 after power-up: the first overvoltage must trip at once
		drv(1'b1, 1'b0);
		wt(0, 1'b1, 20);
		pl(0);
		wt(4, 1'b1, 10);
		rd(IDX_INFO, 32'h7f, 32'h40, OK);
		fin("retry");
		summarize();
	end
endmodule : tb_power_loss_and_fault_retry_ctrl
